// [shared/ptprtc_regs.svh]
// Register offsets, fields, reset values and timing counts of the precision-time clock.
`ifndef PTPRTC_REGS_SVH
`define PTPRTC_REGS_SVH

// Byte addresses of the registers.
`define PTPRTC_OFS_NS_OFFSET      16'h2800
`define PTPRTC_OFS_SEC_LO_OFFSET  16'h2808
`define PTPRTC_OFS_SEC_HI_OFFSET  16'h280c
`define PTPRTC_OFS_INCR_RATE      16'h2810
`define PTPRTC_OFS_NS_SNAP        16'h2814
`define PTPRTC_OFS_SEC_LO_SNAP    16'h2818
`define PTPRTC_OFS_SEC_HI_SNAP    16'h281c
`define PTPRTC_OFS_IRQ_CLEAR      16'h2820
`define PTPRTC_OFS_PHASE_ADJ      16'h2824
`define PTPRTC_OFS_PATH_RESET     16'h2828

// Field widths.
`define PTPRTC_INCR_W      26
`define PTPRTC_FRAC_W      20
`define PTPRTC_NS_W        30
`define PTPRTC_SEC_W       48
`define PTPRTC_SEC_HI_W    16
`define PTPRTC_STEP_W      7
`define PTPRTC_SWRST_W     4

// Bit positions in the write-only registers.
`define PTPRTC_IRQ_CLEAR_BIT   0
`define PTPRTC_RST_TX_BIT      0
`define PTPRTC_RST_RX_BIT      1
`define PTPRTC_RST_PTP_TX_BIT  2
`define PTPRTC_RST_PTP_RX_BIT  3

// Reset values.
`define PTPRTC_RST_INCR     26'h0000000
`define PTPRTC_RST_NS       30'h00000000
`define PTPRTC_RST_SEC      48'h000000000000

// Time constants.
`define PTPRTC_NS_PER_SEC      31'd1000000000
`define PTPRTC_TICK_PERIOD_NS  31'd125000
`define PTPRTC_TICK_HALF_NS    18'd62500
`define PTPRTC_CLK_MHZ         100
`define PTPRTC_SWRST_PULSE_NS  100
`define PTPRTC_SWRST_CYCLES    ((`PTPRTC_SWRST_PULSE_NS * `PTPRTC_CLK_MHZ + 999) / 1000)
`define PTPRTC_REDUCE_STEPS    4'd14

`endif

// [shared/ptprtc_pkg.sv]
// Types shared by the precision-time clock block.
package ptprtc_pkg;

    // Phase generator modes: folding a new start value, or running.
    typedef enum logic [0:0] {
        PTPRTC_TICK_RUN    = 1'b0,
        PTPRTC_TICK_REDUCE = 1'b1
    } ptprtc_tick_state_t;

endpackage : ptprtc_pkg

// [src/ptprtc_counter.sv]
// Nanoseconds and seconds counter with fine fractional increment and step load.
`timescale 1ns/1ps
`include "ptprtc_regs.svh"

module ptprtc_counter (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [`PTPRTC_INCR_W-1:0]   incr_rate,
    input  wire logic                        load,
    input  wire logic [`PTPRTC_NS_W-1:0]     load_ns,
    input  wire logic [`PTPRTC_SEC_W-1:0]    load_sec,
    output logic      [`PTPRTC_NS_W-1:0]     ns,
    output logic      [`PTPRTC_SEC_W-1:0]    sec,
    output logic      [`PTPRTC_STEP_W-1:0]   ns_step
);

    logic [`PTPRTC_FRAC_W-1:0]                frac_reg;
    logic [`PTPRTC_NS_W+`PTPRTC_FRAC_W:0]     sum;
    logic [`PTPRTC_NS_W:0]                    ns_raw;
    logic [`PTPRTC_NS_W:0]                    ns_diff;

    // Fine-unit count plus one increment; a spare bit keeps the carry.
    assign sum     = {1'b0, ns, frac_reg} + {{(`PTPRTC_NS_W + 1 - 6){1'b0}}, incr_rate};
    assign ns_raw  = sum[`PTPRTC_NS_W+`PTPRTC_FRAC_W:`PTPRTC_FRAC_W];
    assign ns_diff = ns_raw - {1'b0, ns};
    // An increment is below 64 ns, so the advance always fits the step width.
    assign ns_step = load ? '0 : ns_diff[`PTPRTC_STEP_W-1:0];

    // Load beats counting so a step lands exactly on the written value.
    always_ff @(posedge clk) begin
        if (reset) begin
            ns       <= `PTPRTC_RST_NS;
            sec      <= `PTPRTC_RST_SEC;
            frac_reg <= '0;
        end else if (load) begin
            ns       <= load_ns;
            sec      <= load_sec;
            frac_reg <= '0;
        end else begin
            frac_reg <= sum[`PTPRTC_FRAC_W-1:0];
            if (ns_raw >= `PTPRTC_NS_PER_SEC) begin
                ns  <= 30'(ns_raw - `PTPRTC_NS_PER_SEC);
                sec <= sec + 48'h1;
            end else begin
                ns <= ns_raw[`PTPRTC_NS_W-1:0];
            end
        end
    end

endmodule : ptprtc_counter

// [src/ptprtc_tick_gen.sv]
// Derived 8 kHz timing signal with nanosecond phase adjustment.
`timescale 1ns/1ps
`include "ptprtc_regs.svh"

module ptprtc_tick_gen (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        load,
    input  wire logic [`PTPRTC_NS_W-1:0]     load_ns,
    input  wire logic [`PTPRTC_NS_W-1:0]     phase_ns,
    input  wire logic [`PTPRTC_STEP_W-1:0]   ns_step,
    output logic                             eight_khz_tick
);

    ptprtc_pkg::ptprtc_tick_state_t state_reg;
    logic [30:0]  rem_reg;
    logic [3:0]   shift_reg;
    logic [30:0]  rem_step;
    logic [30:0]  divisor;
    logic [17:0]  pos_reg;
    logic [17:0]  pos_sum;
    logic [17:0]  pos_next;

    assign divisor  = `PTPRTC_TICK_PERIOD_NS << shift_reg;
    assign rem_step = rem_reg + {24'h0, ns_step};
    assign pos_sum  = pos_reg + {11'h0, ns_step};
    assign pos_next = (pos_sum >= `PTPRTC_TICK_PERIOD_NS) ? 18'(pos_sum - `PTPRTC_TICK_PERIOD_NS) : pos_sum;

    // Restoring modulo over fifteen cycles avoids a wide divider; time keeps flowing.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ptprtc_pkg::PTPRTC_TICK_RUN;
            rem_reg   <= '0;
            shift_reg <= '0;
            pos_reg   <= '0;
        end else if (load) begin
            state_reg <= ptprtc_pkg::PTPRTC_TICK_REDUCE;
            rem_reg   <= {1'b0, load_ns} + {1'b0, phase_ns};
            shift_reg <= `PTPRTC_REDUCE_STEPS;
        end else begin
            case (state_reg)
                ptprtc_pkg::PTPRTC_TICK_REDUCE: begin
                    rem_reg <= (rem_step >= divisor) ? rem_step - divisor : rem_step;
                    if (shift_reg == 4'h0) begin
                        state_reg <= ptprtc_pkg::PTPRTC_TICK_RUN;
                        pos_reg   <= (rem_step >= divisor) ? 18'(rem_step - divisor) : rem_step[17:0];
                    end else begin
                        shift_reg <= shift_reg - 4'h1;
                    end
                end
                ptprtc_pkg::PTPRTC_TICK_RUN: begin
                    pos_reg <= pos_next;
                end
                default: begin
                    state_reg <= ptprtc_pkg::PTPRTC_TICK_RUN;
                end
            endcase
        end
    end

    // High in the first half period; it holds while a new phase is folded.
    always_ff @(posedge clk) begin
        if (reset) begin
            eight_khz_tick <= 1'b1;
        end else if (state_reg == ptprtc_pkg::PTPRTC_TICK_RUN && !load) begin
            eight_khz_tick <= (pos_next < `PTPRTC_TICK_HALF_NS);
        end
    end

endmodule : ptprtc_tick_gen

// [src/ptprtc_top.sv]
// Register file and glue of the precision-time clock block.
`timescale 1ns/1ps
`include "ptprtc_regs.svh"

////////////////////////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Each clock cycle adds the 26-bit increment, in 2^-20 ns units, to the counter.
// - Nanoseconds register reads the 30-bit count, upper two bits zero.
// - Reading nanoseconds captures the seconds so later seconds reads stay coherent.
// - Lower seconds register returns captured seconds bits 31 to 0.
// - Upper seconds register returns captured seconds bits 47 to 32, rest zero.
// - Timer interrupt rises periodically and stays high until software clears it.
// - Any write to the interrupt clear register drops the interrupt unless a timer period arrives in that cycle; reads give zero.
// - Phase value enters the tick generator when offsets load into the counter.
// - Tick is shifted by the phase in nanoseconds; half period inverts it.
// - Bit 0 write of one resets the whole transmit path, configuration kept.
// - Bit 1 write of one resets the whole receive path, configuration kept.
// - Bit 2 write of one resets only precision-time transmit logic.
// - Bit 3 write of one resets only precision-time receive logic.
// - Any combination of reset bits may be set at once; all read zero.
// - Nanoseconds and seconds offsets load together on a nanoseconds offset write.
module ptprtc_top #(
    parameter int TIMER_BIT    = 23,
    parameter int SWRST_CYCLES = `PTPRTC_SWRST_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic [15:0]    reg_addr,
    input  wire logic           reg_wr_en,
    input  wire logic           reg_rd_en,
    input  wire logic [31:0]    reg_wdata,
    output logic      [31:0]    reg_rdata,
    output logic                reg_rd_valid,
    output logic                timer_irq,
    output logic                eight_khz_tick,
    output logic                tx_path_reset,
    output logic                rx_path_reset,
    output logic                ptp_tx_reset,
    output logic                ptp_rx_reset
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [`PTPRTC_INCR_W-1:0]    incr_rate_reg;
    logic [`PTPRTC_NS_W-1:0]      ns_offset_reg;
    logic [31:0]                  sec_lo_offset_reg;
    logic [`PTPRTC_SEC_HI_W-1:0]  sec_hi_offset_reg;
    logic [`PTPRTC_NS_W-1:0]      phase_adj_reg;
    logic [`PTPRTC_SEC_W-1:0]     sec_snap_reg;
    logic                         offset_load_reg;
    logic [`PTPRTC_NS_W-1:0]      ns_now;
    logic [`PTPRTC_SEC_W-1:0]     sec_now;
    logic [`PTPRTC_STEP_W-1:0]    ns_step;
    logic                         timer_bit_reg;
    logic                         timer_event;
    logic                         irq_clear;
    logic                         wr_ns_offset;
    logic                         wr_sec_lo_offset;
    logic                         wr_sec_hi_offset;
    logic                         wr_incr;
    logic                         wr_phase;
    logic                         wr_path_reset;
    logic                         rd_ns_snap;
    logic [31:0]                  rdata_next;
    logic [`PTPRTC_SWRST_W-1:0]   swrst_active;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Address decode of the register port.

    // A write to a read-only address is simply dropped.
    assign wr_ns_offset     = reg_wr_en && (reg_addr == `PTPRTC_OFS_NS_OFFSET);
    assign wr_sec_lo_offset = reg_wr_en && (reg_addr == `PTPRTC_OFS_SEC_LO_OFFSET);
    assign wr_sec_hi_offset = reg_wr_en && (reg_addr == `PTPRTC_OFS_SEC_HI_OFFSET);
    assign wr_incr          = reg_wr_en && (reg_addr == `PTPRTC_OFS_INCR_RATE);
    assign wr_phase         = reg_wr_en && (reg_addr == `PTPRTC_OFS_PHASE_ADJ);
    assign wr_path_reset    = reg_wr_en && (reg_addr == `PTPRTC_OFS_PATH_RESET);
    assign irq_clear        = reg_wr_en && (reg_addr == `PTPRTC_OFS_IRQ_CLEAR);
    assign rd_ns_snap       = reg_rd_en && (reg_addr == `PTPRTC_OFS_NS_SNAP);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Writable configuration registers.

    // Software retunes the increment to follow a remote master.
    always_ff @(posedge clk) begin
        if (reset) begin
            incr_rate_reg <= `PTPRTC_RST_INCR;
        end else if (wr_incr) begin
            incr_rate_reg <= reg_wdata[`PTPRTC_INCR_W-1:0];
        end
    end

    // Offset staging; only the nanoseconds write commits them.
    always_ff @(posedge clk) begin
        if (reset) begin
            ns_offset_reg     <= `PTPRTC_RST_NS;
            sec_lo_offset_reg <= 32'h00000000;
            sec_hi_offset_reg <= 16'h0000;
        end else begin
            if (wr_ns_offset) begin
                ns_offset_reg <= reg_wdata[`PTPRTC_NS_W-1:0];
            end
            if (wr_sec_lo_offset) begin
                sec_lo_offset_reg <= reg_wdata;
            end
            if (wr_sec_hi_offset) begin
                sec_hi_offset_reg <= reg_wdata[`PTPRTC_SEC_HI_W-1:0];
            end
        end
    end

    // Phase staging; it acts only at the next offset commit.
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_adj_reg <= `PTPRTC_RST_NS;
        end else if (wr_phase) begin
            phase_adj_reg <= reg_wdata[`PTPRTC_NS_W-1:0];
        end
    end

    // Commit a cycle after the write, once the new value is staged.
    always_ff @(posedge clk) begin
        if (reset) begin
            offset_load_reg <= 1'b0;
        end else begin
            offset_load_reg <= wr_ns_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Counter and derived timing signal.

    ptprtc_counter u_counter (
        .clk       (clk),
        .reset     (reset),
        .incr_rate (incr_rate_reg),
        .load      (offset_load_reg),
        .load_ns   (ns_offset_reg),
        .load_sec  ({sec_hi_offset_reg, sec_lo_offset_reg}),
        .ns        (ns_now),
        .sec       (sec_now),
        .ns_step   (ns_step)
    );

    // The generator takes phase and offset on the counter's load strobe.
    ptprtc_tick_gen u_tick_gen (
        .clk            (clk),
        .reset          (reset),
        .load           (offset_load_reg),
        .load_ns        (ns_offset_reg),
        .phase_ns       (phase_adj_reg),
        .ns_step        (ns_step),
        .eight_khz_tick (eight_khz_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Coherent snapshot of the seconds field.

    // Seconds freeze on the nanoseconds read so later seconds reads cannot tear.
    always_ff @(posedge clk) begin
        if (reset) begin
            sec_snap_reg <= `PTPRTC_RST_SEC;
        end else if (rd_ns_snap) begin
            sec_snap_reg <= sec_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Periodic timer interrupt.

    // Each change of the chosen nanoseconds bit is a timer period; a step load may add one.
    always_ff @(posedge clk) begin
        if (reset) begin
            timer_bit_reg <= 1'b0;
        end else begin
            timer_bit_reg <= ns_now[TIMER_BIT];
        end
    end

    assign timer_event = (ns_now[TIMER_BIT] != timer_bit_reg);

    // A period arriving with the clear keeps the line high; no tick is lost.
    always_ff @(posedge clk) begin
        if (reset) begin
            timer_irq <= 1'b0;
        end else if (timer_event) begin
            timer_irq <= 1'b1;
        end else if (irq_clear) begin
            timer_irq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Software path resets.

    // One pulse stretcher per request bit; bits of one write start together.
    generate
        for (genvar i = 0; i < `PTPRTC_SWRST_W; i++) begin : g_swrst
            logic [7:0] count_reg;
            always_ff @(posedge clk) begin
                if (reset) begin
                    count_reg <= 8'h00;
                end else if (wr_path_reset && reg_wdata[i]) begin
                    count_reg <= 8'(SWRST_CYCLES);
                end else if (count_reg != 8'h00) begin
                    count_reg <= count_reg - 8'h01;
                end
            end
            assign swrst_active[i] = (count_reg != 8'h00);
        end
    endgenerate

    // Full path resets also cover the precision-time subset; register settings stay.
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_path_reset <= 1'b0;
            rx_path_reset <= 1'b0;
            ptp_tx_reset  <= 1'b0;
            ptp_rx_reset  <= 1'b0;
        end else begin
            tx_path_reset <= swrst_active[`PTPRTC_RST_TX_BIT];
            rx_path_reset <= swrst_active[`PTPRTC_RST_RX_BIT];
            ptp_tx_reset  <= swrst_active[`PTPRTC_RST_PTP_TX_BIT] | swrst_active[`PTPRTC_RST_TX_BIT];
            ptp_rx_reset  <= swrst_active[`PTPRTC_RST_PTP_RX_BIT] | swrst_active[`PTPRTC_RST_RX_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Unused bits, write-only and unmapped addresses read as zero.
    always_comb begin
        rdata_next = 32'h00000000;
        case (reg_addr)
            `PTPRTC_OFS_NS_OFFSET:     rdata_next = {2'b00, ns_offset_reg};
            `PTPRTC_OFS_SEC_LO_OFFSET: rdata_next = sec_lo_offset_reg;
            `PTPRTC_OFS_SEC_HI_OFFSET: rdata_next = {16'h0000, sec_hi_offset_reg};
            `PTPRTC_OFS_INCR_RATE:     rdata_next = {6'h00, incr_rate_reg};
            `PTPRTC_OFS_NS_SNAP:       rdata_next = {2'b00, ns_now};
            `PTPRTC_OFS_SEC_LO_SNAP:   rdata_next = sec_snap_reg[31:0];
            `PTPRTC_OFS_SEC_HI_SNAP:   rdata_next = {16'h0000, sec_snap_reg[47:32]};
            `PTPRTC_OFS_IRQ_CLEAR:     rdata_next = 32'h00000000;
            `PTPRTC_OFS_PHASE_ADJ:     rdata_next = {2'b00, phase_adj_reg};
            `PTPRTC_OFS_PATH_RESET:    rdata_next = 32'h00000000;
            default:                   rdata_next = 32'h00000000;
        endcase
    end

    // Read data is valid one cycle after the strobe and holds until the next read.
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata    <= 32'h00000000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rdata_next;
            end
        end
    end

endmodule : ptprtc_top

// [test/ptprtc_top_props.sv]
// Concurrent checks on the ports of the precision-time clock block.
`timescale 1ns/1ps

module ptprtc_top_props #(
    parameter int SWRST_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rd_valid,
    input wire logic        timer_irq,
    input wire logic        tx_path_reset,
    input wire logic        rx_path_reset,
    input wire logic        ptp_tx_reset,
    input wire logic        ptp_rx_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    int run_len;

    // Cycles the receive reset has stood high.
    always_ff @(posedge clk) begin
        if (reset || !rx_path_reset) begin
            run_len <= 0;
        end else begin
            run_len <= run_len + 1;
        end
    end

    sequence rd_of(logic [15:0] a);
        reg_rd_en && reg_addr == a;
    endsequence

    sequence tx_req_s;
        reg_wr_en && reg_addr == 16'h2828 && reg_wdata[0];
    endsequence

    sequence tx_pulse_s;
        tx_path_reset [*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    rd_valid_pulse_a: assert property (reg_rd_en |=> reg_rd_valid) else $error("read strobe without answer");
    rd_idle_hold_a: assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata))
        else $error("read data moved without a read");
    ns_read_range_a: assert property (rd_of(16'h2814) |=> reg_rdata < 32'd1000000000)
        else $error("nanoseconds read out of range");
    sec_hi_zero_a: assert property (rd_of(16'h281c) |=> reg_rdata[31:16] == 16'h0)
        else $error("upper seconds unused bits set");
    incr_top_zero_a: assert property (rd_of(16'h2810) |=> reg_rdata[31:26] == 6'h0)
        else $error("increment unused bits set");
    irq_clr_zero_a: assert property (rd_of(16'h2820) |=> reg_rdata == 32'h0)
        else $error("interrupt clear read not zero");
    swrst_rd_zero_a: assert property (rd_of(16'h2828) |=> reg_rdata == 32'h0)
        else $error("reset request read not zero");
    irq_hold_a: assert property (timer_irq && !(reg_wr_en && reg_addr == 16'h2820) |=> timer_irq)
        else $error("interrupt dropped without clear");
    tx_pulse_a: assert property (tx_req_s |-> ##2 tx_pulse_s) else $error("transmit reset pulse missing");
    tx_subset_a: assert property (tx_path_reset |-> ptp_tx_reset) else $error("tx subset reset missing");
    rx_subset_a: assert property (rx_path_reset |-> ptp_rx_reset) else $error("rx subset reset missing");
    rx_len_a: assert property ($fell(rx_path_reset) |-> run_len == SWRST_CYCLES)
        else $error("receive reset length wrong");
endmodule : ptprtc_top_props

bind ptprtc_top ptprtc_top_props #(.SWRST_CYCLES(SWRST_CYCLES)) props_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .timer_irq(timer_irq),
    .tx_path_reset(tx_path_reset), .rx_path_reset(rx_path_reset),
    .ptp_tx_reset(ptp_tx_reset), .ptp_rx_reset(ptp_rx_reset));

// [test/ptprtc_host_model.sv]
// Host processor model that drives the register strobe port.
`timescale 1ns/1ps

module ptprtc_host_model (
    input  wire logic        clk,
    output logic      [15:0] reg_addr,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rd_valid
);
    // Idle bus at time zero.
    initial begin
        reg_addr  = 16'h0;
        reg_wdata = 32'h0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end

    // One write; the bus then shows inverted values so stale ones are never trusted.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One read; a missing answer returns unknown so no comparison can pass.
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 32'hx;
    endtask : rd
endmodule : ptprtc_host_model

// [test/ptp_rtc_control_regs_tb.sv]
// Self-checking bench of the precision-time clock block.
`timescale 1ns/1ps

module ptp_rtc_control_regs_tb;
    logic        clk;
    logic        reset;
    logic [15:0] reg_addr;
    logic        reg_wr_en;
    logic        reg_rd_en;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_rd_valid;
    logic        timer_irq;
    logic        eight_khz_tick;
    logic        tx_path_reset;
    logic        rx_path_reset;
    logic        ptp_tx_reset;
    logic        ptp_rx_reset;
    logic [31:0] v;
    int          n;
    int          err_total;
    int          comparisons;
    logic [15:0] rst_addr [8] = '{16'h2810, 16'h2814, 16'h2818, 16'h281c, 16'h2820, 16'h2824, 16'h2828, 16'h2900};
    logic [3:0]  rq [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hf};

    // Short timer bit so the interrupt fires every few cycles.
    ptprtc_top #(.TIMER_BIT(6), .SWRST_CYCLES(10)) DUT (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .timer_irq(timer_irq),
        .eight_khz_tick(eight_khz_tick), .tx_path_reset(tx_path_reset), .rx_path_reset(rx_path_reset),
        .ptp_tx_reset(ptp_tx_reset), .ptp_rx_reset(ptp_rx_reset));

    ptprtc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    // 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_eq(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_eq

    task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
        comparisons++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            err_total++;
            $display("wrong value %s expected %0d..%0d seen %h", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string nm);
        host.rd(a, v);
        chk_eq(nm, e, v);
    endtask : rdc

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        err_total = 0;
        comparisons = 0;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        foreach (rst_addr[i]) rdc(rst_addr[i], 32'h0, "reset value");
        chk_eq("tick after reset", 32'h1, 32'(eight_khz_tick));
        $display("test reset values done");
        // At 10.5 ns a cycle, reads two cycles apart differ by exactly 21 ns.
        host.wr(16'h2810, 32'hfca80000);
        rdc(16'h2810, 32'h00a80000, "increment");
        host.rd(16'h2814, v);
        n = v;
        host.rd(16'h2814, v);
        chk_eq("ns step", 32'd21, v - n);
        $display("test fractional rate done");
        // Load just below a second boundary; captured seconds must stay put.
        host.wr(16'h2810, 32'h00a00000);
        host.wr(16'h2808, 32'hffffffff);
        host.wr(16'h280c, 32'h00001234);
        host.wr(16'h2800, 32'd999999000);
        host.rd(16'h2814, v);
        chk_rng("ns before wrap", 32'd999999000, 32'd999999999, v);
        rdc(16'h2818, 32'hffffffff, "sec low");
        repeat (200) @(negedge clk);
        rdc(16'h281c, 32'h00001234, "sec high held");
        rdc(16'h2818, 32'hffffffff, "sec low held");
        host.rd(16'h2814, v);
        chk_rng("ns after wrap", 32'h0, 32'd3000, v);
        rdc(16'h2818, 32'h0, "sec low wrap");
        rdc(16'h281c, 32'h00001235, "sec high wrap");
        $display("test snapshot and wrap done");
        // The interrupt re-raises while counting, then holds until cleared.
        host.wr(16'h2820, 32'h1);
        n = 0;
        while (timer_irq !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk_eq("irq raised", 32'h1, 32'(timer_irq));
        if (n == 40) end_of_test();
        host.wr(16'h2810, 32'h0);
        repeat (20) @(negedge clk);
        chk_eq("irq held", 32'h1, 32'(timer_irq));
        host.wr(16'h2820, 32'h0);
        @(negedge clk);
        chk_eq("irq cleared", 32'h0, 32'(timer_irq));
        $display("test timer interrupt done");
        // Phase acts only at the next nanoseconds load; half a period inverts the tick.
        host.wr(16'h2810, 32'h00a00000);
        host.wr(16'h2824, 32'h0);
        host.wr(16'h2800, 32'h0);
        repeat (100) @(negedge clk);
        chk_eq("tick phase zero", 32'h1, 32'(eight_khz_tick));
        host.wr(16'h2824, 32'hc000f424);
        rdc(16'h2824, 32'h0000f424, "phase");
        repeat (100) @(negedge clk);
        chk_eq("tick before load", 32'h1, 32'(eight_khz_tick));
        host.wr(16'h2800, 32'h0);
        repeat (100) @(negedge clk);
        chk_eq("tick inverted", 32'h0, 32'(eight_khz_tick));
        repeat (6300) @(negedge clk);
        chk_eq("tick second half", 32'h1, 32'(eight_khz_tick));
        $display("test phase done");
        // Each request pattern: outputs rise a cycle after the write and stand ten cycles.
        foreach (rq[i]) begin
            host.wr(16'h2828, {28'h0, rq[i]});
            @(negedge clk);
            chk_eq("path resets", {28'h0, rq[i][3] | rq[i][1], rq[i][2] | rq[i][0], rq[i][1], rq[i][0]},
                {28'h0, ptp_rx_reset, ptp_tx_reset, rx_path_reset, tx_path_reset});
            n = 0;
            while ((tx_path_reset | rx_path_reset | ptp_tx_reset | ptp_rx_reset) && n < 40) begin
                @(negedge clk);
                n++;
            end
            chk_eq("reset length", 32'd10, n);
        end
        rdc(16'h2810, 32'h00a00000, "rate kept");
        rdc(16'h2828, 32'h0, "reset request read");
        $display("test path resets done");
        end_of_test();
    end
endmodule : ptp_rtc_control_regs_tb
